// File: slcr_pkg.sv
// Purpose: constants and carrier types for the synthesizer / LO configuration register bank
// Assumes: 16-bit registers reached through a same-clock parallel register access port
// Notes: every offset, field position, mask and reset value is defined here; the bench repeats them as literals, the assertions all but the offsets
//
// Functional notes
// - integer divide value plus divide-mode bit
// - 16-bit fractional numerator, reset 0x128
// - 16-bit fractional modulus, reset 0x600
// - mask bit 11 single-rate internal LO
// - mask bit 9 quadrature divide path
// - mask bit 8 external double-rate driver
// - mask bit 7 external single-rate driver
// - remaining mask enables, register resets 0xF67F
// - bit 14 selects external charge pump
// - bits 13:10 coarse pump current
// - bits 5:0 bleed direction and magnitude
// - bits 6:4 reference output mux select
// - bit 3 phase-detector polarity, reset negative
// - bits 2:0 reference multiply/divide ratio
// - bits 15:12 regulator trim four
// - bits 11:8 regulator trim two
// - bits 7:6 external LO amplitude
// - bit 5 halves external driver input
// - bit 4 LO path total eight
// - bit 3 LO path total four

package slcr_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int SLCR_AW = 8; // register address width
  localparam int SLCR_DW = 16; // register data width

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [SLCR_AW-1:0] ADDR_INT_DIV = 8'h02; // integer_divider_value
  localparam logic [SLCR_AW-1:0] ADDR_FRAC_NUM = 8'h03; // fractional_numerator
  localparam logic [SLCR_AW-1:0] ADDR_FRAC_MOD = 8'h04; // fractional_modulus
  localparam logic [SLCR_AW-1:0] ADDR_POWER_MASK = 8'h10; // block_power_mask
  localparam logic [SLCR_AW-1:0] ADDR_PUMP_CFG = 8'h20; // charge_pump_config
  localparam logic [SLCR_AW-1:0] ADDR_DETECTOR_CFG = 8'h21; // phase_detector_reference_config
  localparam logic [SLCR_AW-1:0] ADDR_OSC_PATH_CFG = 8'h22; // oscillator_lo_path_config

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SLCR_DW-1:0] RST_INT_DIV = 16'h002C;
  localparam logic [SLCR_DW-1:0] RST_FRAC_NUM = 16'h0128;
  localparam logic [SLCR_DW-1:0] RST_FRAC_MOD = 16'h0600;
  localparam logic [SLCR_DW-1:0] RST_POWER_MASK = 16'hF67F;
  localparam logic [SLCR_DW-1:0] RST_PUMP_CFG = 16'h0C26;
  localparam logic [SLCR_DW-1:0] RST_DETECTOR_CFG = 16'h000B;
  localparam logic [SLCR_DW-1:0] RST_OSC_PATH_CFG = 16'h2A03;

  // ----------------------------------------------------------------
  // writable-bit masks (zero bits are reserved and never change)
  // ----------------------------------------------------------------
  localparam logic [SLCR_DW-1:0] WM_INT_DIV = 16'h0FFF;
  localparam logic [SLCR_DW-1:0] WM_FRAC_NUM = 16'hFFFF;
  localparam logic [SLCR_DW-1:0] WM_FRAC_MOD = 16'hFFFF;
  localparam logic [SLCR_DW-1:0] WM_POWER_MASK = 16'h0FFE;
  localparam logic [SLCR_DW-1:0] WM_PUMP_CFG = 16'h7C3F;
  localparam logic [SLCR_DW-1:0] WM_DETECTOR_CFG = 16'h007F;
  localparam logic [SLCR_DW-1:0] WM_OSC_PATH_CFG = 16'hFFF8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INT_VAL_MSB = 10;
  localparam int INT_VAL_LSB = 0;
  localparam int INT_MODE_BIT = 11; // 0 fractional, 1 integer
  localparam int PM_SINGLE_RATE_BIT = 11;
  localparam int PM_MODULATOR_BIT = 10;
  localparam int PM_QUAD_DIV_BIT = 9;
  localparam int PM_EXT_DOUBLE_BIT = 8;
  localparam int PM_EXT_SINGLE_BIT = 7;
  localparam int PM_OSC_MUX_BIT = 6;
  localparam int PM_REF_BUF_BIT = 5;
  localparam int PM_OSC_BIT = 4;
  localparam int PM_DIVIDER_BIT = 3;
  localparam int PM_PUMP_BIT = 2;
  localparam int PM_REGULATOR_BIT = 1;
  localparam int CP_SOURCE_BIT = 14;
  localparam int CP_COARSE_MSB = 13;
  localparam int CP_COARSE_LSB = 10;
  localparam int PUMP_BLEED_CURRENT_MSB = 5;
  localparam int PUMP_BLEED_CURRENT_LSB = 0;
  localparam int PUMP_BLEED_CURRENT_DIR_BIT = 5; // 0 sink, 1 source
  localparam int PD_REF_MUX_MSB = 6;
  localparam int PD_REF_MUX_LSB = 4;
  localparam int PD_POLARITY_BIT = 3;
  localparam int PD_REF_SCALE_MSB = 2;
  localparam int PD_REF_SCALE_LSB = 0;
  localparam int OSC_TRIM4_MSB = 15;
  localparam int OSC_TRIM4_LSB = 12;
  localparam int OSC_TRIM2_MSB = 11;
  localparam int OSC_TRIM2_LSB = 8;
  localparam int OSC_AMP_MSB = 7;
  localparam int OSC_AMP_LSB = 6;
  localparam int OSC_HALVE_BIT = 5;
  localparam int OSC_EIGHT_BIT = 4;
  localparam int OSC_FOUR_BIT = 3;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // one register access request, sampled on the clock
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [SLCR_AW-1:0] addr; // register offset
    logic [SLCR_DW-1:0] wdata; // write data
  } slcr_req_t;

  // analog control fields, each a slice of a register flip-flop
  typedef struct packed {
    logic [10:0] integer_divide; // integer divide value
    logic integer_mode; // 1 integer, 0 fractional
    logic [15:0] fraction_numerator; // fractional numerator
    logic [15:0] fraction_modulus; // fractional modulus
    logic single_rate_internal_lo_en; // single-rate LO from oscillator
    logic modulator_power_en; // modulator chain
    logic quad_divide_path_en; // quadrature divide path
    logic ext_double_rate_driver_en; // ext driver ahead of quad divider
    logic ext_single_rate_driver_en; // ext driver after quad divider
    logic oscillator_mux_en; // oscillator mux
    logic reference_buffer_en; // reference buffer
    logic oscillator_power_en; // oscillators
    logic divider_power_en; // oscillator dividers
    logic pump_power_en; // charge pump
    logic oscillator_regulator_en; // oscillator regulator
    logic pump_source_select; // 1 external pump
    logic [3:0] pump_coarse_current; // coarse current code
    logic [5:0] pump_bleed_current; // bleed direction and magnitude
    logic [2:0] reference_output_select; // reference output mux
    logic detector_polarity; // 1 negative
    logic [2:0] reference_input_scale; // multiply/divide ratio
    logic [3:0] regulator_trim_four; // regulator resistor four trim
    logic [3:0] regulator_trim_two; // regulator resistor two trim
    logic [1:0] ext_lo_amplitude; // external LO level
    logic ext_driver_halve_en; // halve ahead of ext driver
    logic lo_total_eight_en; // LO path total of eight
    logic lo_total_four_en; // LO path total of four
  } slcr_ctrl_t;

endpackage

// File: slcr_field_reg.sv
// Purpose: one 16-bit configuration register with fixed reserved bits
// Assumes: synchronous active-low reset, clock enable freezes state
// Notes: bits outside WMASK hold their reset value forever

`timescale 1ns/1ps

module slcr_field_reg #(
  parameter logic [15:0] RESET = 16'h0000, // reset value
  parameter logic [15:0] WMASK = 16'hFFFF // writable bits
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic ce_i, // clock enable
  input wire logic we_i, // write strobe
  input wire logic [15:0] wdata_i, // write data
  output logic [15:0] q_o // register contents
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // reset wins over the enable so a frozen bank still comes up defined
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q_o <= RESET;
    end
    else if (ce_i && we_i)
    begin
      q_o <= (wdata_i & WMASK) | (RESET & ~WMASK);
    end
  end

endmodule // slcr_field_reg

// File: slcr_top.sv
// Purpose: configuration register bank for the synthesizer and LO path
// Assumes: requests come from logic on CLK_I, so no synchronisers
// Notes: fields drive analog controls directly; read data one cycle later

`timescale 1ns/1ps

module slcr_top (
  input wire logic CLK_I, // 50 MHz clock
  input wire logic RST_N_I, // sync reset, active low
  input wire logic CE_I, // clock enable, freezes state when low
  input wire slcr_pkg::slcr_req_t REQ_I, // register access request
  output logic [slcr_pkg::SLCR_DW-1:0] RDATA_O, // read data, registered
  output logic RVALID_O, // read data valid pulse
  output logic ADDR_ERR_O, // unmapped access pulse
  output slcr_pkg::slcr_ctrl_t CTRL_O // analog control fields
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [6:0] hit; // one-hot register select
  logic mapped; // address names a register
  logic [slcr_pkg::SLCR_DW-1:0] rd_mux; // selected register value
  logic [slcr_pkg::SLCR_DW-1:0] r_int; // integer_divider_value
  logic [slcr_pkg::SLCR_DW-1:0] r_num; // fractional_numerator
  logic [slcr_pkg::SLCR_DW-1:0] r_mod; // fractional_modulus
  logic [slcr_pkg::SLCR_DW-1:0] r_pwr; // block_power_mask
  logic [slcr_pkg::SLCR_DW-1:0] r_cp; // charge_pump_config
  logic [slcr_pkg::SLCR_DW-1:0] r_pd; // phase_detector_reference_config
  logic [slcr_pkg::SLCR_DW-1:0] r_osc; // oscillator_lo_path_config
  logic wr_go; // write taken this cycle
  logic rd_go; // read taken this cycle

  assign wr_go = CE_I && REQ_I.wr;
  assign rd_go = CE_I && REQ_I.rd;

  // decode the offset into a register select and the read value
  always_comb
  begin
    hit = 7'h00;
    rd_mux = 16'h0000;
    mapped = 1'b1;
    if (REQ_I.addr == slcr_pkg::ADDR_INT_DIV)
    begin
      hit[0] = 1'b1;
      rd_mux = r_int;
    end
    else if (REQ_I.addr == slcr_pkg::ADDR_FRAC_NUM)
    begin
      hit[1] = 1'b1;
      rd_mux = r_num;
    end
    else if (REQ_I.addr == slcr_pkg::ADDR_FRAC_MOD)
    begin
      hit[2] = 1'b1;
      rd_mux = r_mod;
    end
    else if (REQ_I.addr == slcr_pkg::ADDR_POWER_MASK)
    begin
      hit[3] = 1'b1;
      rd_mux = r_pwr;
    end
    else if (REQ_I.addr == slcr_pkg::ADDR_PUMP_CFG)
    begin
      hit[4] = 1'b1;
      rd_mux = r_cp;
    end
    else if (REQ_I.addr == slcr_pkg::ADDR_DETECTOR_CFG)
    begin
      hit[5] = 1'b1;
      rd_mux = r_pd;
    end
    else if (REQ_I.addr == slcr_pkg::ADDR_OSC_PATH_CFG)
    begin
      hit[6] = 1'b1;
      rd_mux = r_osc;
    end
    else
    begin
      mapped = 1'b0; // unmapped: reads zero, writes dropped
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // integer value and divide mode
  slcr_field_reg #(.RESET(slcr_pkg::RST_INT_DIV), .WMASK(slcr_pkg::WM_INT_DIV)) u_int (
    .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(wr_go && hit[0]),
    .wdata_i(REQ_I.wdata), .q_o(r_int));
  // numerator
  slcr_field_reg #(.RESET(slcr_pkg::RST_FRAC_NUM), .WMASK(slcr_pkg::WM_FRAC_NUM)) u_num (
    .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(wr_go && hit[1]),
    .wdata_i(REQ_I.wdata), .q_o(r_num));
  // modulus
  slcr_field_reg #(.RESET(slcr_pkg::RST_FRAC_MOD), .WMASK(slcr_pkg::WM_FRAC_MOD)) u_mod (
    .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(wr_go && hit[2]),
    .wdata_i(REQ_I.wdata), .q_o(r_mod));
  // power mask, reserved bits pinned to their reset ones
  slcr_field_reg #(.RESET(slcr_pkg::RST_POWER_MASK), .WMASK(slcr_pkg::WM_POWER_MASK)) u_pwr (
    .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(wr_go && hit[3]),
    .wdata_i(REQ_I.wdata), .q_o(r_pwr));
  // charge pump
  slcr_field_reg #(.RESET(slcr_pkg::RST_PUMP_CFG), .WMASK(slcr_pkg::WM_PUMP_CFG)) u_cp (
    .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(wr_go && hit[4]),
    .wdata_i(REQ_I.wdata), .q_o(r_cp));
  // detector and reference
  slcr_field_reg #(.RESET(slcr_pkg::RST_DETECTOR_CFG), .WMASK(slcr_pkg::WM_DETECTOR_CFG)) u_pd (
    .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(wr_go && hit[5]),
    .wdata_i(REQ_I.wdata), .q_o(r_pd));
  // oscillator and LO path; low three bits are outside this bank
  slcr_field_reg #(.RESET(slcr_pkg::RST_OSC_PATH_CFG), .WMASK(slcr_pkg::WM_OSC_PATH_CFG)) u_osc (
    .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(wr_go && hit[6]),
    .wdata_i(REQ_I.wdata), .q_o(r_osc));

  // ----------------------------------------------------------------
  // field outputs, each a straight slice of a register flip-flop
  // ----------------------------------------------------------------
  assign CTRL_O.integer_divide = r_int[slcr_pkg::INT_VAL_MSB:slcr_pkg::INT_VAL_LSB];
  assign CTRL_O.integer_mode = r_int[slcr_pkg::INT_MODE_BIT];
  assign CTRL_O.fraction_numerator = r_num;
  assign CTRL_O.fraction_modulus = r_mod;
  assign CTRL_O.single_rate_internal_lo_en = r_pwr[slcr_pkg::PM_SINGLE_RATE_BIT];
  assign CTRL_O.modulator_power_en = r_pwr[slcr_pkg::PM_MODULATOR_BIT];
  assign CTRL_O.quad_divide_path_en = r_pwr[slcr_pkg::PM_QUAD_DIV_BIT];
  assign CTRL_O.ext_double_rate_driver_en = r_pwr[slcr_pkg::PM_EXT_DOUBLE_BIT];
  assign CTRL_O.ext_single_rate_driver_en = r_pwr[slcr_pkg::PM_EXT_SINGLE_BIT];
  assign CTRL_O.oscillator_mux_en = r_pwr[slcr_pkg::PM_OSC_MUX_BIT];
  assign CTRL_O.reference_buffer_en = r_pwr[slcr_pkg::PM_REF_BUF_BIT];
  assign CTRL_O.oscillator_power_en = r_pwr[slcr_pkg::PM_OSC_BIT];
  assign CTRL_O.divider_power_en = r_pwr[slcr_pkg::PM_DIVIDER_BIT];
  assign CTRL_O.pump_power_en = r_pwr[slcr_pkg::PM_PUMP_BIT];
  assign CTRL_O.oscillator_regulator_en = r_pwr[slcr_pkg::PM_REGULATOR_BIT];
  assign CTRL_O.pump_source_select = r_cp[slcr_pkg::CP_SOURCE_BIT];
  assign CTRL_O.pump_coarse_current = r_cp[slcr_pkg::CP_COARSE_MSB:slcr_pkg::CP_COARSE_LSB];
  // bleed keeps its direction bit on top of the magnitude
  assign CTRL_O.pump_bleed_current = r_cp[slcr_pkg::PUMP_BLEED_CURRENT_MSB:slcr_pkg::PUMP_BLEED_CURRENT_LSB];
  assign CTRL_O.reference_output_select = r_pd[slcr_pkg::PD_REF_MUX_MSB:slcr_pkg::PD_REF_MUX_LSB];
  assign CTRL_O.detector_polarity = r_pd[slcr_pkg::PD_POLARITY_BIT];
  assign CTRL_O.reference_input_scale = r_pd[slcr_pkg::PD_REF_SCALE_MSB:slcr_pkg::PD_REF_SCALE_LSB];
  assign CTRL_O.regulator_trim_four = r_osc[slcr_pkg::OSC_TRIM4_MSB:slcr_pkg::OSC_TRIM4_LSB];
  assign CTRL_O.regulator_trim_two = r_osc[slcr_pkg::OSC_TRIM2_MSB:slcr_pkg::OSC_TRIM2_LSB];
  assign CTRL_O.ext_lo_amplitude = r_osc[slcr_pkg::OSC_AMP_MSB:slcr_pkg::OSC_AMP_LSB];
  assign CTRL_O.ext_driver_halve_en = r_osc[slcr_pkg::OSC_HALVE_BIT];
  assign CTRL_O.lo_total_eight_en = r_osc[slcr_pkg::OSC_EIGHT_BIT];
  assign CTRL_O.lo_total_four_en = r_osc[slcr_pkg::OSC_FOUR_BIT];

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // a read in the same cycle as a write to the same offset sees the old value
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      RDATA_O <= 16'h0000;
      RVALID_O <= 1'b0;
    end
    else if (CE_I)
    begin
      RVALID_O <= REQ_I.rd;
      if (REQ_I.rd)
      begin
        RDATA_O <= rd_mux;
      end
    end
  end

  // unmapped strobes flag one cycle; useful for catching bad driver tables
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      ADDR_ERR_O <= 1'b0;
    end
    else if (CE_I)
    begin
      ADDR_ERR_O <= (REQ_I.rd || REQ_I.wr) && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // write to one offset, then nothing
  sequence wr_to(logic [7:0] a);
    wr_go && REQ_I.addr == a;
  endsequence

  // a write of a given offset followed by its read back
  sequence wr_then_rd(logic [7:0] a);
    wr_to(a) ##1 (rd_go && !REQ_I.wr && REQ_I.addr == a);
  endsequence

  int_divide_a: assert property (
    wr_to(slcr_pkg::ADDR_INT_DIV) |=>
      CTRL_O.integer_divide == $past(REQ_I.wdata[10:0]) && CTRL_O.integer_mode == $past(REQ_I.wdata[11]))
    else $error("integer divide field not loaded");

  numerator_load_a: assert property (
    wr_to(slcr_pkg::ADDR_FRAC_NUM) |=> CTRL_O.fraction_numerator == $past(REQ_I.wdata))
    else $error("fraction numerator not loaded");

  modulus_load_a: assert property (
    wr_to(slcr_pkg::ADDR_FRAC_MOD) |=> CTRL_O.fraction_modulus == $past(REQ_I.wdata))
    else $error("fraction modulus not loaded");

  lo_enables_a: assert property (
    wr_to(slcr_pkg::ADDR_POWER_MASK) |=>
      CTRL_O.single_rate_internal_lo_en == $past(REQ_I.wdata[11])
      && CTRL_O.quad_divide_path_en == $past(REQ_I.wdata[9])
      && CTRL_O.ext_double_rate_driver_en == $past(REQ_I.wdata[8])
      && CTRL_O.ext_single_rate_driver_en == $past(REQ_I.wdata[7]))
    else $error("LO enable bits wrong after mask write");

  mask_reserved_a: assert property (
    wr_to(slcr_pkg::ADDR_POWER_MASK) |=> r_pwr[15:12] == 4'hF && r_pwr[0] == 1'b1
      && CTRL_O.modulator_power_en == $past(REQ_I.wdata[10])
      && CTRL_O.oscillator_regulator_en == $past(REQ_I.wdata[1]))
    else $error("power mask reserved or block bits wrong");

  reset_values_a: assert property (
    !$past(RST_N_I) |-> r_int == 16'h002C && r_num == 16'h0128 && r_mod == 16'h0600
      && r_pwr == 16'hF67F && r_cp == 16'h0C26 && r_pd == 16'h000B && r_osc == 16'h2A03)
    else $error("register not at reset value after reset");

  pump_fields_a: assert property (
    wr_to(slcr_pkg::ADDR_PUMP_CFG) |=>
      CTRL_O.pump_source_select == $past(REQ_I.wdata[14])
      && CTRL_O.pump_coarse_current == $past(REQ_I.wdata[13:10])
      && CTRL_O.pump_bleed_current == $past(REQ_I.wdata[5:0]) && r_cp[15] == 1'b0 && r_cp[9:6] == 4'h0)
    else $error("charge pump fields wrong after write");

  detector_fields_a: assert property (
    wr_to(slcr_pkg::ADDR_DETECTOR_CFG) |=>
      CTRL_O.reference_output_select == $past(REQ_I.wdata[6:4])
      && CTRL_O.detector_polarity == $past(REQ_I.wdata[3])
      && CTRL_O.reference_input_scale == $past(REQ_I.wdata[2:0]) && r_pd[15:7] == 9'h000)
    else $error("detector fields wrong after write");

  osc_fields_a: assert property (
    wr_to(slcr_pkg::ADDR_OSC_PATH_CFG) |=>
      CTRL_O.regulator_trim_four == $past(REQ_I.wdata[15:12])
      && CTRL_O.regulator_trim_two == $past(REQ_I.wdata[11:8])
      && CTRL_O.ext_lo_amplitude == $past(REQ_I.wdata[7:6])
      && CTRL_O.ext_driver_halve_en == $past(REQ_I.wdata[5])
      && CTRL_O.lo_total_eight_en == $past(REQ_I.wdata[4])
      && CTRL_O.lo_total_four_en == $past(REQ_I.wdata[3]) && r_osc[2:0] == 3'h3)
    else $error("oscillator path fields wrong after write");

  hold_unwritten_a: assert property (
    !(wr_go && mapped) |=> $stable(r_int) && $stable(r_num) && $stable(r_mod)
      && $stable(r_pwr) && $stable(r_cp) && $stable(r_pd) && $stable(r_osc))
    else $error("register changed without a write");

  read_back_a: assert property (
    wr_then_rd(slcr_pkg::ADDR_PUMP_CFG) |=> RVALID_O && RDATA_O == r_cp)
    else $error("read back does not match stored value");

  unmapped_read_a: assert property (
    rd_go && !mapped |=> RVALID_O && ADDR_ERR_O && RDATA_O == 16'h0000)
    else $error("unmapped read not answered with zero");

endmodule // slcr_top

// File: slcr_top_tb.sv
// Purpose: self-checking bench for the synthesizer / LO configuration register bank
// Assumes: same-clock register port; requests launched by NBA on the rising edge
// Notes: expectations come from the reset values, writable masks and field layout

`timescale 1ns/1ps

module slcr_top_tb;
  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 50 MHz bench clock
  logic rst_n = 1'b0; // sync reset, active low
  logic ce = 1'b1; // clock enable
  slcr_pkg::slcr_req_t req = '0; // register request
  logic [15:0] rdata; // read data seen
  logic rvalid; // read answer pulse
  logic addr_err; // unmapped access pulse
  slcr_pkg::slcr_ctrl_t ctrl; // analog control fields
  int fails = 0; // mismatches seen
  int comparisons = 0; // checks made
  int cycles = 0; // hang guard
  logic [7:0] adr [7] = '{8'h02, 8'h03, 8'h04, 8'h10, 8'h20, 8'h21, 8'h22}; // mapped offsets
  logic [15:0] rst_v [7] = '{16'h002C, 16'h0128, 16'h0600, 16'hF67F, 16'h0C26, 16'h000B, 16'h2A03};
  logic [15:0] wm [7] = '{16'h0FFF, 16'hFFFF, 16'hFFFF, 16'h0FFE, 16'h7C3F, 16'h007F, 16'hFFF8};

  slcr_top u_slcr_top (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REQ_I(req), .RDATA_O(rdata),
    .RVALID_O(rvalid), .ADDR_ERR_O(addr_err), .CTRL_O(ctrl));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  // generous ceiling: the whole sequence needs well under 500 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    comparisons = comparisons + 1;
    if (seen !== expv)
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    if (seen !== expv)
      fails = fails + 1;
  endtask

  // one access: launched after an edge, taken at the next, answer sampled just after it
  task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] expv);
    access(1'b0, 1'b1, a, 16'h0000);
    chk(16'(rvalid), 16'h0001);
    chk(16'(addr_err), 16'h0000);
    chk(rdata, expv);
  endtask

  // reset readback plus the field outputs that the reset values imply
  task automatic check_resets();
    for (int i = 0; i < 7; i++)
      rd_chk(adr[i], rst_v[i]);
    chk(16'({ctrl.integer_mode, ctrl.integer_divide}), 16'h002C);
    chk(ctrl.fraction_numerator, 16'h0128);
    chk(ctrl.fraction_modulus, 16'h0600);
    chk(16'({ctrl.single_rate_internal_lo_en, ctrl.modulator_power_en, ctrl.quad_divide_path_en,
      ctrl.ext_double_rate_driver_en, ctrl.ext_single_rate_driver_en, ctrl.oscillator_mux_en,
      ctrl.reference_buffer_en, ctrl.oscillator_power_en, ctrl.divider_power_en, ctrl.pump_power_en,
      ctrl.oscillator_regulator_en}), 16'h033F);
    chk(16'({ctrl.pump_source_select, ctrl.pump_coarse_current, ctrl.pump_bleed_current}),
      16'({1'b0, 4'h3, 6'h26}));
    chk(16'({ctrl.reference_output_select, ctrl.detector_polarity, ctrl.reference_input_scale}),
      16'h000B);
    chk(16'({ctrl.regulator_trim_four, ctrl.regulator_trim_two, ctrl.ext_lo_amplitude,
      ctrl.ext_driver_halve_en, ctrl.lo_total_eight_en, ctrl.lo_total_four_en}),
      16'({4'h2, 4'hA, 2'h0, 3'b000}));
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    check_resets();
    $display("test reset values done");
    // all ones then all zeros: reserved bits must keep their reset value
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 7; i++)
      begin
        access(1'b1, 1'b0, adr[i], p == 0 ? 16'hFFFF : 16'h0000);
        rd_chk(adr[i], ((p == 0 ? 16'hFFFF : 16'h0000) & wm[i]) | (rst_v[i] & ~wm[i]));
      end
    $display("test reserved bits done");
    // distinct patterns land in the right field outputs
    access(1'b1, 1'b0, 8'h02, 16'h0ABC);
    access(1'b1, 1'b0, 8'h03, 16'h8001);
    access(1'b1, 1'b0, 8'h04, 16'h7FFE);
    access(1'b1, 1'b0, 8'h10, 16'h0A81);
    access(1'b1, 1'b0, 8'h20, 16'h5C21);
    access(1'b1, 1'b0, 8'h21, 16'h0054);
    access(1'b1, 1'b0, 8'h22, 16'h9A68);
    chk(16'({ctrl.integer_mode, ctrl.integer_divide}), 16'h0ABC);
    chk(ctrl.fraction_numerator, 16'h8001);
    chk(ctrl.fraction_modulus, 16'h7FFE);
    chk(16'({ctrl.single_rate_internal_lo_en, ctrl.modulator_power_en, ctrl.quad_divide_path_en,
      ctrl.ext_double_rate_driver_en, ctrl.ext_single_rate_driver_en, ctrl.oscillator_mux_en,
      ctrl.reference_buffer_en, ctrl.oscillator_power_en, ctrl.divider_power_en, ctrl.pump_power_en,
      ctrl.oscillator_regulator_en}), 16'h0540);
    chk(16'({ctrl.pump_source_select, ctrl.pump_coarse_current, ctrl.pump_bleed_current}),
      16'({1'b1, 4'h7, 6'h21}));
    chk(16'({ctrl.reference_output_select, ctrl.detector_polarity, ctrl.reference_input_scale}),
      16'h0054);
    chk(16'({ctrl.regulator_trim_four, ctrl.regulator_trim_two, ctrl.ext_lo_amplitude,
      ctrl.ext_driver_halve_en, ctrl.lo_total_eight_en, ctrl.lo_total_four_en}),
      16'({4'h9, 4'hA, 2'h1, 3'b101}));
    rd_chk(8'h10, 16'hFA81);
    rd_chk(8'h22, 16'h9A6B);
    $display("test field mapping done");
    // read and write together: read returns the old contents
    access(1'b1, 1'b1, 8'h20, 16'h0000);
    chk(rdata, 16'h5C21);
    rd_chk(8'h20, 16'h0000);
    // write then read on the very next edge: the read sees the new contents
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h20, wdata: 16'h1234};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h20, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    chk(16'(rvalid), 16'h0001);
    chk(rdata, 16'h1034);
    // unmapped read and write: flagged, no side effect
    access(1'b0, 1'b1, 8'h05, 16'h0000);
    chk(16'(addr_err), 16'h0001);
    chk(rdata, 16'h0000);
    access(1'b1, 1'b0, 8'h11, 16'h0000);
    chk(16'(addr_err), 16'h0001);
    rd_chk(8'h10, 16'hFA81);
    // clock enable low: a write is not taken, the field holds
    @(posedge clk);
    ce <= 1'b0;
    access(1'b1, 1'b0, 8'h21, 16'h0008);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(8'h21, 16'h0054);
    $display("test access corners done");
    // reset in mid-run restores every register and field
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_resets();
    $display("test second reset done");
    report_and_stop();
  end
endmodule // slcr_top_tb
